// File: verilog/analog_freq_command_select.sv
`timescale 1ns/1ps
`default_nettype none
module analog_freq_command_select #(
  parameter int FILTER_DEPTH_MAX = 30
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [afcs_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [afcs_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic current_voltage_choice,
  input wire afcs_pkg::samples_t analog_samples,
  input wire logic sample_valid,
  output logic [afcs_pkg::CMD_W-1:0] freq_command,
  output logic reverse_cmd,
  output logic trim_active,
  output logic analog_selected
);
  import afcs_pkg::*;

  if (FILTER_DEPTH_MAX < 1 || FILTER_DEPTH_MAX > FILTER_MAX) begin : g_chk
    $error("FILTER_DEPTH_MAX must lie between 1 and 30");
  end

  state_t st;
  state_t nx;
  logic [4:0] eff;
  logic signed [CMD_W-1:0] fv;
  logic signed [CMD_W-1:0] fc;
  logic signed [CMD_W-1:0] fb;
  logic signed [CMD_W-1:0] main_val;
  logic signed [CMD_W-1:0] total;
  logic rev_ok;
  logic [31:0] ctrl_word;
  logic [31:0] wmask;

  always_comb begin
    eff = st.cfg.depth;
    if (eff < FILTER_MIN) begin
      eff = FILTER_MIN;
    end
    if (eff > 5'(FILTER_DEPTH_MAX)) begin
      eff = 5'(FILTER_DEPTH_MAX);
    end
    // Shared divisor keeps all three channels on the same time constant
    fv = CMD_W'($signed(st.sum[0]) / $signed({1'b0, eff}));
    fc = CMD_W'($signed(st.sum[1]) / $signed({1'b0, eff}));
    fb = CMD_W'($signed(st.sum[2]) / $signed({1'b0, eff}));
    ctrl_word = 32'h0;
    ctrl_word[CTRL_FS_LSB +: 8] = st.cfg.fs;
    ctrl_word[CTRL_ALT_LSB +: 2] = st.cfg.alt;
    ctrl_word[CTRL_MODE_LSB +: 2] = st.cfg.mode;
    ctrl_word[CTRL_ASSIGN_BIT] = st.cfg.assigned;
    ctrl_word[CTRL_DEPTH_LSB +: 5] = st.cfg.depth;
    wmask = {{8{st.wstrb[3]}}, {8{st.wstrb[2]}}, {8{st.wstrb[1]}}, {8{st.wstrb[0]}}};
    nx = st;

    // Three-stage synchroniser; a change counts once stages two and three agree
    nx.sync = {st.sync[1:0], current_voltage_choice};
    if (st.sync[1] == st.sync[2]) begin
      nx.choice = st.sync[2];
    end

    // Moving average: a depth change restarts the window from zero
    nx.eff_prev = eff;
    if (eff != st.eff_prev) begin
      nx.hist = '0;
      nx.sum = '0;
    end else if (sample_valid) begin
      for (int c = 0; c < 3; c++) begin
        nx.sum[c] = st.sum[c] - SUM_W'($signed(st.hist[eff-5'h01][c]));
      end
      nx.sum[0] = nx.sum[0] + SUM_W'({1'b0, analog_samples.volt});
      nx.sum[1] = nx.sum[1] + SUM_W'({1'b0, analog_samples.curr});
      nx.sum[2] = nx.sum[2] + SUM_W'(analog_samples.bip);
      for (int k = FILTER_MAX - 1; k > 0; k--) begin
        nx.hist[k] = st.hist[k-1];
      end
      // Element c of a history slot must hold the same channel as sum[c]
      nx.hist[0] = {{analog_samples.bip[SAMPLE_W-1], analog_samples.bip},
                    {1'b0, analog_samples.curr}, {1'b0, analog_samples.volt}};
    end

    // Selection is recomputed every cycle from the synchronised terminal
    nx.sel = SRC_VOLT;
    nx.trim = 1'b0;
    rev_ok = 1'b0;
    main_val = fv;
    if (!st.cfg.assigned) begin
      if (st.cfg.mode == MODE_UNI || st.cfg.mode == MODE_BI) begin
        nx.sel = SRC_SUM;
        main_val = fv + fc;
        nx.trim = 1'b1;
        rev_ok = st.cfg.mode == MODE_BI;
      end else begin
        nx.sel = SRC_BIP;
        main_val = fb;
        rev_ok = 1'b1;
      end
    end else if (!st.choice) begin
      nx.sel = SRC_VOLT;
      nx.trim = st.cfg.mode == MODE_UNI || st.cfg.mode == MODE_BI;
      rev_ok = st.cfg.mode == MODE_BI;
    end else if (st.cfg.alt == ALT_BIPOLAR) begin
      nx.sel = SRC_BIP;
      main_val = fb;
      rev_ok = 1'b1;
    end else begin
      nx.sel = SRC_CURR;
      main_val = fc;
      nx.trim = st.cfg.mode == MODE_UNI || st.cfg.mode == MODE_BI;
      rev_ok = st.cfg.mode == MODE_BI;
    end
    total = main_val + (nx.trim ? fb : CMD_W'(0));
    nx.rev = 1'b0;
    nx.cmd = CMD_W'(total);
    if (total < 0) begin
      // Without reverse the negative sum is clamped, never turned round
      nx.rev = rev_ok;
      nx.cmd = rev_ok ? CMD_W'(-total) : CMD_W'(0);
    end
    nx.analog = st.cfg.fs == FS_ANALOG;
    if (!nx.analog) begin
      nx.cmd = '0;
      nx.rev = 1'b0;
      nx.trim = 1'b0;
    end

    // AXI4-Lite write: address and data taken in either order
    if (awvalid && st.awready) begin
      nx.aw_held = 1'b1;
      nx.awaddr = awaddr;
    end
    if (wvalid && st.wready) begin
      nx.w_held = 1'b1;
      nx.wdata = wdata;
      nx.wstrb = wstrb;
    end
    if (st.bvalid && bready) begin
      nx.bvalid = 1'b0;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      nx.aw_held = 1'b0;
      nx.w_held = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp = RESP_OKAY;
      if (st.awaddr == ADDR_CTRL) begin
        ctrl_word = ((ctrl_word & ~wmask) | (st.wdata & wmask)) & CTRL_MASK;
        nx.cfg.fs = ctrl_word[CTRL_FS_LSB +: 8];
        nx.cfg.alt = ctrl_word[CTRL_ALT_LSB +: 2];
        nx.cfg.mode = ctrl_word[CTRL_MODE_LSB +: 2];
        nx.cfg.assigned = ctrl_word[CTRL_ASSIGN_BIT];
        nx.cfg.depth = ctrl_word[CTRL_DEPTH_LSB +: 5];
      end else if (st.awaddr != ADDR_STATUS && st.awaddr != ADDR_COMMAND) begin
        nx.bresp = RESP_SLVERR;
      end
    end
    nx.awready = !nx.aw_held && !nx.bvalid;
    nx.wready = !nx.w_held && !nx.bvalid;

    // AXI4-Lite read
    if (st.rvalid && rready) begin
      nx.rvalid = 1'b0;
    end
    if (arvalid && st.arready) begin
      nx.rvalid = 1'b1;
      nx.rresp = RESP_OKAY;
      case (araddr)
        ADDR_CTRL: begin
          nx.rdata = ctrl_word;
        end
        ADDR_STATUS: begin
          nx.rdata = {21'h0, eff, st.sel, st.choice, st.analog, st.rev, st.trim};
        end
        ADDR_COMMAND: begin
          nx.rdata = 32'(st.cmd);
        end
        default: begin
          nx.rdata = 32'h0;
          nx.rresp = RESP_SLVERR;
        end
      endcase
    end
    nx.arready = !nx.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.cfg.fs <= CTRL_RESET[CTRL_FS_LSB +: 8];
      st.cfg.assigned <= CTRL_RESET[CTRL_ASSIGN_BIT];
      st.cfg.depth <= CTRL_RESET[CTRL_DEPTH_LSB +: 5];
      st.eff_prev <= FILTER_MIN;
    end else begin
      st <= nx;
    end
  end

  assign awready = st.awready;
  assign wready = st.wready;
  assign bvalid = st.bvalid;
  assign bresp = st.bresp;
  assign arready = st.arready;
  assign rvalid = st.rvalid;
  assign rdata = st.rdata;
  assign rresp = st.rresp;
  assign freq_command = st.cmd;
  assign reverse_cmd = st.rev;
  assign trim_active = st.trim;
  assign analog_selected = st.analog;

  sequence s_choice_on_alt(logic [1:0] a);
    st.cfg.assigned && st.choice && st.cfg.alt == a;
  endsequence

  AST_VOLT_MAIN: assert property (@(posedge aclk) disable iff (!aresetn)
    st.cfg.assigned && !st.choice |=> st.sel == SRC_VOLT) else $error("voltage channel not selected");
  AST_CURR_MAIN: assert property (@(posedge aclk) disable iff (!aresetn)
    s_choice_on_alt(2'h0) |=> st.sel == SRC_CURR) else $error("current channel not selected");
  AST_BIP_MAIN: assert property (@(posedge aclk) disable iff (!aresetn)
    s_choice_on_alt(ALT_BIPOLAR) |=> st.sel == SRC_BIP && !st.trim) else $error("bipolar main wrong");
  AST_TRIM: assert property (@(posedge aclk) disable iff (!aresetn)
    st.cfg.mode == MODE_NONE |=> !st.trim) else $error("trim added in mode 00");
  AST_NO_REV: assert property (@(posedge aclk) disable iff (!aresetn)
    st.cfg.mode != MODE_BI && st.sel != SRC_BIP && nx.sel != SRC_BIP |=> !st.rev)
    else $error("reverse without permission");
  AST_REV_SIGN: assert property (@(posedge aclk) disable iff (!aresetn)
    st.rev |-> st.analog && st.cmd != '0) else $error("reverse with zero command");
  AST_IGNORE_ALT: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.cfg.assigned && st.cfg.mode == MODE_NONE |=> st.sel == SRC_BIP) else $error("unassigned mode 00");
  AST_SUM: assert property (@(posedge aclk) disable iff (!aresetn)
    !st.cfg.assigned && st.cfg.mode == MODE_UNI |=> st.sel == SRC_SUM && !st.rev) else $error("summation");
  AST_DEPTH: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 eff >= 5'h01 && eff <= 5'h1E) else $error("filter depth out of range");
  AST_FS_GATE: assert property (@(posedge aclk) disable iff (!aresetn)
    st.cfg.fs != FS_ANALOG |=> st.cmd == '0 && !st.analog) else $error("command not gated");
  AST_AVG1: assert property (@(posedge aclk) disable iff (!aresetn)
    sample_valid && eff == 5'h01 && st.eff_prev == 5'h01 |=> st.sum[0] == SUM_W'($past(analog_samples.volt)))
    else $error("depth 1 average wrong");
  AST_CHOICE: assert property (@(posedge aclk) disable iff (!aresetn)
    st.sync[2] == st.sync[1] ##1 st.sync[2] == st.sync[1] |-> st.choice == $past(st.sync[2]))
    else $error("choice terminal not followed");
endmodule
`default_nettype wire

// File: verilog/afcs_pkg.sv
package afcs_pkg;
  localparam int SAMPLE_W = 12;
  localparam int HIST_W = SAMPLE_W + 1;
  localparam int SUM_W = SAMPLE_W + 6;
  localparam int CMD_W = SAMPLE_W + 3;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_COMMAND = 8'h08;
  localparam int CTRL_FS_LSB = 0;
  localparam int CTRL_ALT_LSB = 8;
  localparam int CTRL_MODE_LSB = 12;
  localparam int CTRL_ASSIGN_BIT = 16;
  localparam int CTRL_DEPTH_LSB = 24;
  localparam logic [31:0] CTRL_RESET = 32'h0101_0001;
  localparam logic [31:0] CTRL_MASK = 32'h1F01_33FF;
  localparam logic [7:0] FS_ANALOG = 8'h01;
  localparam logic [1:0] ALT_BIPOLAR = 2'h1;
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_UNI = 2'h1;
  localparam logic [1:0] MODE_BI = 2'h2;
  localparam logic [4:0] FILTER_MIN = 5'h01;
  localparam int FILTER_MAX = 30;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SRC_VOLT = 2'b00,
    SRC_CURR = 2'b01,
    SRC_BIP = 2'b11,
    SRC_SUM = 2'b10
  } src_t;

  typedef struct packed {
    logic [SAMPLE_W-1:0] volt;
    logic [SAMPLE_W-1:0] curr;
    logic signed [SAMPLE_W-1:0] bip;
  } samples_t;

  typedef struct packed {
    logic [7:0] fs;
    logic [1:0] alt;
    logic [1:0] mode;
    logic assigned;
    logic [4:0] depth;
  } cfg_t;

  typedef struct packed {
    cfg_t cfg;
    logic [2:0] sync;
    logic choice;
    logic [4:0] eff_prev;
    logic [FILTER_MAX-1:0][2:0][HIST_W-1:0] hist;
    logic [2:0][SUM_W-1:0] sum;
    src_t sel;
    logic trim;
    logic rev;
    logic analog;
    logic [CMD_W-1:0] cmd;
    logic aw_held;
    logic [ADDR_W-1:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;
endpackage

// File: test/analog_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_source_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire afcs_pkg::samples_t value,
  input wire logic go,
  input wire logic [3:0] lag,
  output var afcs_pkg::samples_t samples,
  output logic sample_valid
);
  import afcs_pkg::*;
  logic [4:0] count_reg;
  samples_t held_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 5'h00;
      sample_valid <= 1'b0;
      samples <= '0;
    end else begin
      sample_valid <= 1'b0;
      // Data flips every cycle between strobes, so a sample read one cycle late is inverted
      samples <= ~samples;
      if (go) begin
        held_reg <= value;
        count_reg <= {1'b0, lag} + 5'h01;
      end else if (count_reg == 5'h01) begin
        sample_valid <= 1'b1;
        samples <= held_reg;
        count_reg <= 5'h00;
      end else if (count_reg != 5'h00) begin
        count_reg <= count_reg - 5'h01;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/analog_freq_command_select_bench.sv
`timescale 1ns/1ps
`default_nettype none
module analog_freq_command_select_bench;
  import afcs_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, current_voltage_choice, go;
  logic awready, wready, bvalid, arready, rvalid, reverse_cmd, trim_active, analog_selected, sample_valid;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, lag;
  logic [1:0] bresp, rresp, md, al;
  logic [CMD_W-1:0] freq_command;
  logic [67:0] it;
  logic [67:0] exp_q[$];
  samples_t req, analog_samples;
  src_t src;
  logic asg, rev, trim;
  int err_total, checks_done, seed, i, v, c, b, tot, mag, acc;
  analog_freq_command_select analog_freq_command_select_i (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .current_voltage_choice, .analog_samples, .sample_valid,
    .freq_command, .reverse_cmd, .trim_active, .analog_selected);
  analog_source_model analog_source_model_i (.aclk, .aresetn, .value(req), .go, .lag, .samples(analog_samples),
    .sample_valid);
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input string what, input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (g !== e) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Read answers are judged by the monitor below, oldest note first
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      it = exp_q.pop_front();
      chk("read", it[33:0], {rresp, rdata} & it[67:34]);
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw_hit, w_hit, b_hit;
    logic [1:0] r;
    int n;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    b_hit = 1'b0;
    for (n = 0; n < 50 && !b_hit; n++) begin
      @(negedge aclk);
      aw_hit = awvalid && awready;
      w_hit = wvalid && wready;
      b_hit = bvalid && bready;
      r = bresp;
      @(posedge aclk);
      if (aw_hit) awvalid <= 1'b0;
      if (w_hit) wvalid <= 1'b0;
      if (b_hit) bready <= 1'b0;
    end
    // One idle edge keeps the next call from driving bready in this time step
    @(posedge aclk);
    chk("bresp", {32'h0, er}, {32'h0, r});
    if (!b_hit) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] m);
    logic ar_hit, r_hit;
    int n;
    exp_q.push_back({m, e});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    r_hit = 1'b0;
    for (n = 0; n < 50 && !r_hit; n++) begin
      @(negedge aclk);
      ar_hit = arvalid && arready;
      r_hit = rvalid && rready;
      @(posedge aclk);
      if (ar_hit) arvalid <= 1'b0;
      if (r_hit) rready <= 1'b0;
    end
    @(posedge aclk);
    if (!r_hit) begin
      err_total++;
      conclude();
    end
  endtask
  task automatic send(input samples_t s);
    int n;
    req <= s;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    for (n = 0; n < 40 && !sample_valid; n++) @(posedge aclk);
    if (n == 40) begin
      err_total++;
      conclude();
    end
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    seed = 11;
    {awvalid, wvalid, bready, arvalid, rready, current_voltage_choice, go, lag} = '0;
    {awaddr, araddr, wdata, wstrb, req} = '0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(ADDR_CTRL, {RESP_OKAY, CTRL_RESET}, 34'h3_FFFF_FFFF);
    wr(ADDR_CTRL, 32'hFFFF_FF02, 4'h1, RESP_OKAY);
    send({12'd500, 12'd0, 12'd0});
    rd(ADDR_COMMAND, {RESP_OKAY, 32'h0}, 34'h3_FFFF_FFFF);
    chk("analog_selected", 34'h0, {33'h0, analog_selected});
    rd(8'h0C, {RESP_SLVERR, 32'h0}, 34'h3_FFFF_FFFF);
    wr(8'h10, 32'h0, 4'hF, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    wr(ADDR_CTRL, 32'h0001_0001, 4'hF, RESP_OKAY);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h40}, 34'h7C0);
    wr(ADDR_CTRL, 32'h1F01_0001, 4'hF, RESP_OKAY);
    rd(ADDR_STATUS, {RESP_OKAY, 32'h780}, 34'h7C0);
    for (i = 0; i < 24; i++) begin
      asg = i >= 12;
      md = 2'((i / 4) % 3);
      al = {1'b0, i[1]};
      lag <= 4'(i % 3);
      current_voltage_choice <= i[0];
      wr(ADDR_CTRL, {8'h01, 7'h0, asg, 2'h0, md, 2'h0, al, 8'h01}, 4'hF, RESP_OKAY);
      repeat (8) @(posedge aclk);
      if (!asg) src = (md == MODE_NONE) ? SRC_BIP : SRC_SUM;
      else if (!i[0]) src = SRC_VOLT;
      else src = (al == ALT_BIPOLAR) ? SRC_BIP : SRC_CURR;
      trim = md != MODE_NONE && src != SRC_BIP;
      v = $unsigned($random(seed)) % 1024;
      c = $unsigned($random(seed)) % 1024;
      b = $random(seed) % 1024;
      if (trim && md == MODE_UNI && b < 0) b = -b;
      tot = (src == SRC_VOLT ? v : src == SRC_CURR ? c : src == SRC_BIP ? b : v + c) + (trim ? b : 0);
      rev = (md == MODE_BI || src == SRC_BIP) && tot < 0;
      mag = tot < 0 ? (rev ? -tot : 0) : tot;
      send({12'(v), 12'(c), 12'(b)});
      rd(ADDR_STATUS, {RESP_OKAY, 21'h0, 5'h01, src, i[0], 1'b1, rev, trim}, 34'h7FF);
      rd(ADDR_COMMAND, {RESP_OKAY, 17'h0, 15'(mag)}, 34'h3_FFFF_FFFF);
      chk("outputs", {17'h0, trim, rev, 15'(mag)}, {17'h0, trim_active, reverse_cmd, freq_command});
    end
    wr(ADDR_CTRL, 32'h0100_1001, 4'hF, RESP_OKAY);
    send({12'd0, 12'd0, -12'sd500});
    chk("outputs", 34'h1_0000, {17'h0, trim_active, reverse_cmd, freq_command});
    rd(ADDR_STATUS, {RESP_OKAY, 32'h5}, 34'h7);
    current_voltage_choice <= 1'b0;
    wr(ADDR_CTRL, 32'h0401_0001, 4'hF, RESP_OKAY);
    repeat (8) @(posedge aclk);
    acc = 0;
    for (i = 1; i < 6; i++) begin
      acc = acc + 100 * i - (i > 4 ? 100 * (i - 4) : 0);
      send({12'(100 * i), 12'd0, 12'd0});
      rd(ADDR_COMMAND, {RESP_OKAY, 32'(acc / 4)}, 34'h3_FFFF_FFFF);
    end
    conclude();
  end
endmodule
`default_nettype wire
